// ===== rtl/mapper_regs.svh
`ifndef MAPPER_REGS_SVH
`define MAPPER_REGS_SVH
// address arithmetic
`define FILE_BASE        8'd10
`define FILE_STRIDE      14'd100
`define FILE_MAX         8'd146
`define BULK_FILE        8'd60
`define REG_MIN          14'd1
`define REG_MAX          14'd13668
`define BULK_ENTRIES     6'd32
`define BULK_OFS_MAX     14'd31
`endif

// ===== rtl/mapper_pkg.sv
package mapper_pkg;
   typedef enum logic [1:0] {SVC_NONE, SVC_TYPED_READ, SVC_TYPED_WRITE, SVC_OTHER} service_t;
   typedef enum logic [1:0] {ST_OK, ST_BAD_SERVICE, ST_BAD_ADDRESS, ST_BAD_ASCII} status_t;
endpackage : mapper_pkg

// ===== rtl/mapper_if.sv
`timescale 1ns/1ps
interface mapper_if;
   import mapper_pkg::*;
   logic              req_valid;
   logic              req_ready;
   service_t          req_service;
   logic              req_ascii;
   logic              req_int_file;
   logic [7:0]        req_file;
   logic [13:0]       req_offset;
   logic [5:0]        req_count;
   logic              wr_valid;
   logic [15:0]       wr_data;
   logic              rd_valid;
   logic [15:0]       rd_data;
   logic              done;
   status_t           status;
   logic              timeout_event;
   modport device (input req_valid, req_service, req_ascii, req_int_file, req_file,
                   req_offset, req_count, wr_valid, wr_data,
                   output req_ready, rd_valid, rd_data, done, status, timeout_event);
   modport controller (output req_valid, req_service, req_ascii, req_int_file, req_file,
                       req_offset, req_count, wr_valid, wr_data,
                       input req_ready, rd_valid, rd_data, done, status, timeout_event);
endinterface : mapper_if

// ===== rtl/address_mapper.sv
`timescale 1ns/1ps
`include "mapper_regs.svh"
// Functional notes
// - read via typed read, write via typed write
// - binary and ascii addressing; ascii integer only
// - register = (file-10)*100 + offset
// - files 10..146, register 1..13668, offset limited
// - bulk read follows produced array order
// - bulk write scatters via consumed array
// - bulk arrays 32 entries, start 0..31
// - timeout or socket error raises timeout event
// - controller gives start address and count
// - controller writes single-word values only on change; multi-word writes always go out
// - no concurrent cyclic and explicit writes
// - one outstanding read request at most
module address_mapper
   import mapper_pkg::*;
#(
   parameter int REG_AW = 14
)(
   input  wire logic              clock,
   input  wire logic              rst_b,
   mapper_if.device               link,
   input  wire logic              conn_timeout,
   input  wire logic              socket_error,
   input  wire logic [REG_AW-1:0] produced_map [32],
   input  wire logic [REG_AW-1:0] consumed_map [32],
   output logic                   reg_rd,
   output logic                   reg_wr,
   output logic [REG_AW-1:0]      reg_addr,
   output logic [15:0]            reg_wdata,
   input  wire logic [15:0]       reg_rdata
);
   typedef enum logic [1:0] {IDLE, READ, WRITE, FINISH} state_t;

   // ==========================================================
   // request decode
   // ==========================================================
   wire logic        is_bulk   = link.req_file == `BULK_FILE;
   wire logic [7:0]  file_rel  = link.req_file - `FILE_BASE;
   wire logic [20:0] std_reg   = 21'(file_rel) * 21'(`FILE_STRIDE) + 21'(link.req_offset);
   wire logic [20:0] last_reg  = std_reg + 21'(link.req_count) - 21'd1;
   wire logic        std_ok    = link.req_file >= `FILE_BASE && link.req_file <= `FILE_MAX
                                 && link.req_offset <= `REG_MAX && std_reg >= 21'(`REG_MIN)
                                 && last_reg <= 21'(`REG_MAX);
   wire logic        bulk_ok   = link.req_offset <= `BULK_OFS_MAX
                                 && 7'(link.req_offset) + 7'(link.req_count) <= 7'(`BULK_ENTRIES);
   wire logic        svc_ok    = link.req_service == SVC_TYPED_READ
                                 || link.req_service == SVC_TYPED_WRITE;
   wire logic        ascii_ok  = !link.req_ascii || link.req_int_file;
   wire logic        cnt_ok    = link.req_count != 6'd0;
   wire logic        addr_ok   = cnt_ok && (is_bulk ? bulk_ok : std_ok);
   wire status_t     chk       = !svc_ok ? ST_BAD_SERVICE : !ascii_ok ? ST_BAD_ASCII :
                                 !addr_ok ? ST_BAD_ADDRESS : ST_OK;

   state_t            state_reg;
   logic              bulk_reg;
   logic [13:0]       ptr_reg;
   logic [5:0]        left_reg;
   logic              rd_pend_reg;
   logic [1:0]        tmo_sync1_reg;
   logic [1:0]        tmo_sync2_reg;

   // bulk pointer selects the mapping entry, else linear register
   wire logic [4:0]        idx      = ptr_reg[4:0];
   wire logic [REG_AW-1:0] rd_target = bulk_reg ? produced_map[idx] : REG_AW'(ptr_reg);
   wire logic [REG_AW-1:0] wr_target = bulk_reg ? consumed_map[idx] : REG_AW'(ptr_reg);
   wire logic              accept    = state_reg == IDLE && link.req_valid;
   wire logic              step_wr   = state_reg == WRITE && link.wr_valid;
   wire logic              step_rd   = state_reg == READ && !rd_pend_reg;

   // ==========================================================
   // sequencer
   // ==========================================================
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg      <= IDLE;
         bulk_reg       <= 1'b0;
         ptr_reg        <= 14'h0;
         left_reg       <= 6'h0;
         rd_pend_reg    <= 1'b0;
         link.req_ready <= 1'b0;
         link.rd_valid  <= 1'b0;
         link.rd_data   <= 16'h0;
         link.done      <= 1'b0;
         link.status    <= ST_OK;
         reg_rd         <= 1'b0;
         reg_wr         <= 1'b0;
         reg_addr       <= '0;
         reg_wdata      <= 16'h0;
      end
      else
      begin
         link.req_ready <= state_reg == IDLE;
         link.done      <= 1'b0;
         link.rd_valid  <= rd_pend_reg;
         link.rd_data   <= reg_rdata;
         reg_rd         <= 1'b0;
         reg_wr         <= 1'b0;
         rd_pend_reg    <= 1'b0;
         case (state_reg)
            IDLE:
            begin
               if (accept)
               begin
                  bulk_reg    <= is_bulk;
                  ptr_reg     <= is_bulk ? link.req_offset : std_reg[13:0];
                  left_reg    <= link.req_count;
                  link.status <= chk;
                  link.req_ready <= 1'b0;
                  if (chk != ST_OK)
                     state_reg <= FINISH;
                  else if (link.req_service == SVC_TYPED_READ)
                     state_reg <= READ;
                  else
                     state_reg <= WRITE;
               end
            end
            READ:
            begin
               if (step_rd)
               begin
                  reg_rd      <= 1'b1;
                  reg_addr    <= rd_target;
                  rd_pend_reg <= 1'b1;
                  ptr_reg     <= ptr_reg + 14'd1;
                  left_reg    <= left_reg - 6'd1;
                  if (left_reg == 6'd1)
                     state_reg <= FINISH;
               end
            end
            WRITE:
            begin
               if (step_wr)
               begin
                  reg_wr    <= 1'b1;
                  reg_addr  <= wr_target;
                  reg_wdata <= link.wr_data;
                  ptr_reg   <= ptr_reg + 14'd1;
                  left_reg  <= left_reg - 6'd1;
                  if (left_reg == 6'd1)
                     state_reg <= FINISH;
               end
            end
            FINISH:
            begin
               // wait for the last read word to come back before done
               if (!rd_pend_reg)
               begin
                  link.done <= 1'b1;
                  state_reg <= IDLE;
               end
            end
            default:
               state_reg <= IDLE;
         endcase
      end
   end

   // ==========================================================
   // timeout event
   // ==========================================================
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tmo_sync1_reg      <= 2'b00;
         tmo_sync2_reg      <= 2'b00;
         link.timeout_event <= 1'b0;
      end
      else
      begin
         // each cause synchronised on its own; the merge happens after the second stage
         tmo_sync1_reg      <= {socket_error, conn_timeout};
         tmo_sync2_reg      <= tmo_sync1_reg;
         link.timeout_event <= |tmo_sync2_reg;
      end
   end
endmodule : address_mapper

// ===== rtl/controller_end.sv
`timescale 1ns/1ps
`include "mapper_regs.svh"
module controller_end
   import mapper_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   mapper_if.controller     link,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic        cmd_ascii,
   input  wire logic [7:0]  cmd_file,
   input  wire logic [13:0] cmd_offset,
   input  wire logic [5:0]  cmd_count,
   input  wire logic [15:0] cmd_wdata,
   output logic             cmd_busy,
   output logic             resp_valid,
   output logic [15:0]      resp_data,
   output logic             resp_done,
   output status_t          resp_status
);
   typedef enum logic [1:0] {C_IDLE, C_REQ, C_WAIT} cstate_t;
   cstate_t     st_reg;
   logic [15:0] last_wr_reg;
   logic        wr_seen_reg;
   // write skipped when single-word value unchanged, saves nvm wear
   wire logic   same_wr = cmd_write && wr_seen_reg && cmd_count == 6'd1
                          && cmd_wdata == last_wr_reg;
   wire logic   launch  = st_reg == C_IDLE && cmd_valid && !same_wr;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg            <= C_IDLE;
         last_wr_reg       <= 16'h0;
         wr_seen_reg       <= 1'b0;
         cmd_busy          <= 1'b0;
         resp_valid        <= 1'b0;
         resp_data         <= 16'h0;
         resp_done         <= 1'b0;
         resp_status       <= ST_OK;
         link.req_valid    <= 1'b0;
         link.req_service  <= SVC_NONE;
         link.req_ascii    <= 1'b0;
         link.req_int_file <= 1'b1;
         link.req_file     <= `FILE_BASE;
         link.req_offset   <= 14'h0;
         link.req_count    <= 6'h0;
         link.wr_valid     <= 1'b0;
         link.wr_data      <= 16'h0;
      end
      else
      begin
         resp_valid <= link.rd_valid;
         resp_data  <= link.rd_data;
         resp_done  <= link.done;
         link.wr_valid <= 1'b0;
         case (st_reg)
            C_IDLE:
            begin
               if (launch)
               begin
                  link.req_valid   <= 1'b1;
                  link.req_service <= cmd_write ? SVC_TYPED_WRITE : SVC_TYPED_READ;
                  link.req_ascii   <= cmd_ascii;
                  link.req_file    <= cmd_file;
                  link.req_offset  <= cmd_offset;
                  link.req_count   <= cmd_count;
                  link.wr_data     <= cmd_wdata;
                  cmd_busy         <= 1'b1;
                  if (cmd_write)
                  begin
                     last_wr_reg <= cmd_wdata;
                     wr_seen_reg <= 1'b1;
                  end
                  st_reg <= C_REQ;
               end
            end
            C_REQ:
            begin
               if (link.req_ready)
               begin
                  link.req_valid <= 1'b0;
                  st_reg         <= C_WAIT;
               end
            end
            C_WAIT:
            begin
               // write words all carry the latched value, one per cycle
               link.wr_valid <= link.req_service == SVC_TYPED_WRITE && !link.done;
               if (link.done)
               begin
                  resp_status <= link.status;
                  cmd_busy    <= 1'b0;
                  st_reg      <= C_IDLE;
               end
            end
            default:
               st_reg <= C_IDLE;
         endcase
      end
   end
endmodule : controller_end

// ===== test/mapper_monitor.sv
`timescale 1ns/1ps
module mapper_monitor
   import mapper_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst_b,
   input wire logic       req_valid,
   input wire logic       req_ready,
   input wire service_t   req_service,
   input wire logic [7:0] req_file,
   input wire logic [5:0] req_count,
   input wire logic       rd_valid,
   input wire logic       done,
   input wire status_t    status,
   input wire logic       timeout_event,
   input wire logic       conn_timeout,
   input wire logic       socket_error
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // ==========================================
   // request tracking
   wire       acc = req_valid && req_ready;
   wire       bad_file = req_file < 8'h0A || req_file > 8'h92;
   logic [5:0] cnt_reg;
   logic [5:0] len_reg;
   service_t   svc_reg;
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_reg <= 6'h00;
         len_reg <= 6'h00;
         svc_reg <= SVC_NONE;
      end
      else if (acc)
      begin
         cnt_reg <= 6'h00;
         len_reg <= req_count;
         svc_reg <= req_service;
      end
      else if (rd_valid)
         cnt_reg <= cnt_reg + 6'h01;
   end
   // ==========================================
   // properties
   one_done_a: assert property (done |=> !done)
      else $error("done held longer than one cycle");
   busy_ready_a: assert property (acc |=> !req_ready)
      else $error("ready stayed high after accept");
   bounded_done_a: assert property (acc |-> ##[2:200] done)
      else $error("request never completed");
   bad_file_a: assert property (acc && bad_file |-> ##2 done && status == ST_BAD_ADDRESS)
      else $error("bad file not refused");
   no_data_a: assert property (acc && bad_file |=> !rd_valid [*3])
      else $error("data returned for bad file");
   word_count_a: assert property (done && status == ST_OK && svc_reg == SVC_TYPED_READ
      |-> cnt_reg == len_reg)
      else $error("read word count differs from request");
   read_only_a: assert property (rd_valid |-> svc_reg == SVC_TYPED_READ && !req_ready)
      else $error("read data outside a read");
   conn_to_a: assert property ($rose(conn_timeout) |-> ##[2:4] timeout_event)
      else $error("connection timeout not signalled");
   sock_err_a: assert property ($rose(socket_error) |-> ##[2:4] timeout_event)
      else $error("socket error not signalled");
   quiet_a: assert property ((!conn_timeout && !socket_error) [*4] |-> !timeout_event)
      else $error("timeout event without cause");
   cover property (acc && req_service == SVC_TYPED_READ && req_file == 8'h3C);
   cover property (acc && req_service == SVC_TYPED_WRITE && req_count > 6'h01);
   cover property (done && status == ST_BAD_ADDRESS);
endmodule : mapper_monitor

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench
   import mapper_pkg::*;
;
   logic        clock, rst_b, cmd_valid, cmd_write, cmd_ascii, conn_timeout, socket_error;
   logic        cmd_busy, resp_valid, resp_done, reg_rd, reg_wr;
   logic [7:0]  cmd_file;
   logic [13:0] cmd_offset, reg_addr;
   logic [5:0]  cmd_count;
   logic [15:0] cmd_wdata, resp_data, reg_wdata, reg_rdata;
   status_t     resp_status, st;
   logic [13:0] produced_map [32];
   logic [13:0] consumed_map [32];
   logic [15:0] mem [16384];
   logic [15:0] got [$];
   int          err_count = 0;
   int          n_tests = 0;
   mapper_if bus();
   address_mapper u_address_mapper (.clock(clock), .rst_b(rst_b), .link(bus),
      .conn_timeout(conn_timeout), .socket_error(socket_error),
      .produced_map(produced_map), .consumed_map(consumed_map), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   controller_end u_controller_end (.clock(clock), .rst_b(rst_b), .link(bus),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_ascii(cmd_ascii),
      .cmd_file(cmd_file), .cmd_offset(cmd_offset), .cmd_count(cmd_count),
      .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .resp_valid(resp_valid),
      .resp_data(resp_data), .resp_done(resp_done), .resp_status(resp_status));
   mapper_monitor u_mapper_monitor (.clock(clock), .rst_b(rst_b),
      .req_valid(bus.req_valid), .req_ready(bus.req_ready), .req_service(bus.req_service),
      .req_file(bus.req_file), .req_count(bus.req_count), .rd_valid(bus.rd_valid),
      .done(bus.done), .status(bus.status), .timeout_event(bus.timeout_event),
      .conn_timeout(conn_timeout), .socket_error(socket_error));
   // ==========================================
   // register space behind the mapper
   // falling edge, so read data stands before the mapper captures it on the next rise
   always @(negedge clock)
   begin
      if (reg_wr) mem[reg_addr] <= reg_wdata;
      if (reg_rd) reg_rdata <= mem[reg_addr];
   end
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ==========================================
   // tasks
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic cmp(input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask : cmp
   task automatic cmp_st(input status_t e);
      cmp({14'h0000, e}, {14'h0000, st});
   endtask : cmp_st
   // one command through the controller end; n is the expected word count
   task automatic run(input logic w, input logic a, input logic [7:0] f,
                      input logic [13:0] o, input logic [5:0] c, input logic [15:0] d,
                      input int n);
      int k;
      got.delete();
      {cmd_write, cmd_ascii, cmd_file, cmd_offset, cmd_count, cmd_wdata} = {w, a, f, o, c, d};
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      cmp(16'h0001, 16'(cmd_busy));
      for (k = 0; k < 400; k++)
      begin
         if (resp_valid === 1'b1) got.push_back(resp_data);
         if (resp_done === 1'b1) break;
         @(negedge clock);
      end
      st = resp_status;
      if (k == 400)
      begin
         err_count++;
         wrap_up();
      end
      cmp(16'(n), 16'(got.size()));
      cmp(16'h0000, 16'(cmd_busy));
      repeat (3) @(negedge clock);
   endtask : run
   // ==========================================
   // scenarios
   initial
   begin
      logic [7:0]  bf [7] = '{8'h09, 8'h93, 8'h92, 8'h0A, 8'h3C, 8'h3C, 8'h0A};
      logic [13:0] bo [7] = '{14'h0000, 14'h0000, 14'h0045, 14'h0000, 14'h001F, 14'h0020,
                              14'h0002};
      logic [5:0]  bc [7] = '{6'h01, 6'h01, 6'h01, 6'h01, 6'h02, 6'h01, 6'h00};
      {rst_b, cmd_valid, cmd_write, cmd_ascii, conn_timeout, socket_error} = '0;
      {cmd_file, cmd_offset, cmd_count, cmd_wdata} = '0;
      for (int i = 0; i < 32; i++)
      begin
         produced_map[i] = 14'(200 + 7 * i);
         consumed_map[i] = 14'(500 + 5 * i);
      end
      for (int i = 0; i < 16384; i++) mem[i] = 16'(i * 3 + 1);
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      repeat (2) @(negedge clock);
      run(1, 0, 8'h0A, 14'h0002, 6'h01, 16'h1234, 0); cmp_st(ST_OK);
      run(0, 0, 8'h0A, 14'h0002, 6'h01, 16'h0000, 1); cmp(16'h1234, got[0]);
      run(1, 0, 8'h0C, 14'h003E, 6'h01, 16'hABCD, 0);
      run(0, 1, 8'h0B, 14'h00A2, 6'h01, 16'h0000, 1); cmp(16'hABCD, got[0]);
      run(1, 1, 8'h1B, 14'h0062, 6'h03, 16'h5A5A, 0);
      run(0, 0, 8'h14, 14'h031E, 6'h03, 16'h0000, 3);
      for (int k = 0; k < 3; k++) cmp(16'h5A5A, got[k]);
      run(1, 0, 8'h92, 14'h0044, 6'h01, 16'h7E57, 0); cmp(16'h7E57, mem[13668]);
      for (int k = 0; k < 7; k++)
      begin
         run(0, 0, bf[k], bo[k], bc[k], 16'h0000, 0); cmp_st(ST_BAD_ADDRESS);
      end
      run(1, 0, 8'h0A, 14'h0000, 6'h01, 16'h0F0F, 0); cmp(16'h0001, mem[0]);
      run(1, 0, 8'h3C, 14'h001E, 6'h02, 16'hC0DE, 0); cmp(16'hC0DE, mem[consumed_map[31]]);
      cmp(16'hC0DE, mem[consumed_map[30]]);
      run(0, 0, 8'h3C, 14'h001D, 6'h03, 16'h0000, 3);
      for (int k = 0; k < 3; k++) cmp(mem[produced_map[29 + k]], got[k]);
      for (int s = 1; s < 3; s++)
      begin
         {socket_error, conn_timeout} = 2'(s);
         repeat (5) @(negedge clock);
         cmp(16'h0001, {15'h0000, bus.timeout_event});
         {socket_error, conn_timeout} = 2'b00;
         repeat (6) @(negedge clock);
         cmp(16'h0000, {15'h0000, bus.timeout_event});
      end
      wrap_up();
   end
endmodule : testbench
